// *** sample_rate_level_control.sv ***
`timescale 1ns/1ns
module sample_rate_level_control (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic por,
  input wire logic dsp_mode,
  input wire logic codec_partner_select,
  input wire logic adc_calibrate,
  input wire rate_level_pkg::reg_req_t req,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic [15:0] rate_reg_out,
  output logic [17:0] rate_sevenths,
  output logic rate_reserved,
  output logic dac_force_mid,
  output logic [8:0] dac_gain_tenths,
  output logic dac_gain_neg,
  output logic dac_gain_valid,
  output logic adc_input_select,
  output logic [8:0] adc_gain_tenths,
  input wire logic [15:0] adc_sample_in,
  input wire logic adc_sample_valid,
  output logic [15:0] adc_sample_out,
  output logic adc_sample_out_valid,
  input wire logic [15:0] dac_sample_in,
  input wire logic dac_sample_valid,
  output logic [15:0] dac_sample_out,
  output logic dac_sample_out_valid
);
  logic [15:0] rate_q, rate_d;
  logic [7:0] hold_q, hold_d;
  logic [15:0] level_q, level_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [15:0] adc_q, adc_d, dac_q, dac_d;
  logic adcv_q, adcv_d, dacv_q, dacv_d;
  logic [17:0] rs_w, rs_q;
  logic rr_w, rr_q;
  logic [8:0] dg_w, dg_q, ag_w, ag_q;
  logic dn_w, dn_q, dv_w, dv_q;
  rate_level_pkg::level_t lvl;
  logic rate_hit, level_hit;

  assign lvl = rate_level_pkg::level_t'({level_q[15], level_q[12:8], level_q[7], level_q[5:0]});
  assign rate_hit = req.addr == rate_level_pkg::RATE_REG_ADDR;
  assign level_hit = req.addr == rate_level_pkg::LEVEL_REG_ADDR;

  rate_calc rate_calc_inst (
    .rate_reg(rate_q),
    .rate_sevenths(rs_w),
    .rate_reserved(rr_w)
  );

  level_calc level_calc_inst (
    .lvl(lvl),
    .codec_partner_select(codec_partner_select),
    .dac_gain_tenths(dg_w),
    .dac_gain_neg(dn_w),
    .dac_gain_valid(dv_w),
    .adc_gain_tenths(ag_w)
  );

  // register writes; the host keeps writes clear of calibration windows
  always_comb begin
    rate_d = rate_q;
    hold_d = hold_q;
    level_d = level_q;
    if (req.wr && rate_hit) begin
      if (dsp_mode) begin
        if (req.lo_en) begin
          hold_d = req.wdata[7:0];
        end
        if (req.hi_en) begin
          rate_d = {req.wdata[15:8], req.lo_en ? req.wdata[7:0] : hold_q};
        end
      end else begin
        rate_d = req.wdata;
        hold_d = req.wdata[7:0];
      end
    end
    if (req.wr && level_hit) begin
      // reserved bits stay zero
      if (req.hi_en) begin
        level_d[15:8] = req.wdata[15:8] & rate_level_pkg::LEVEL_WMASK[15:8];
      end
      if (req.lo_en) begin
        level_d[7:0] = req.wdata[7:0] & rate_level_pkg::LEVEL_WMASK[7:0];
      end
    end
  end

  // only power-up loads the defaults, so plain rst leaves the values; 16000 Hz from power-up
  always_ff @(posedge sys_clk) begin
    if (por) begin
      rate_q <= rate_level_pkg::RATE_RESET;
      hold_q <= rate_level_pkg::RATE_RESET[7:0];
      level_q <= rate_level_pkg::LEVEL_RESET;
    end else begin
      rate_q <= rate_d;
      hold_q <= hold_d;
      level_q <= level_d;
    end
  end

  // read path, answer one cycle after the request
  always_comb begin
    rdata_d = 16'h0000;
    rvalid_d = req.rd;
    if (req.rd && rate_hit) begin
      rdata_d = {rate_q[15:8], dsp_mode ? hold_q : rate_q[7:0]};
    end else if (req.rd && level_hit) begin
      rdata_d = level_q;
    end
  end

  // sample muting: midscale is two's complement zero
  always_comb begin
    adcv_d = adc_sample_valid;
    adc_d = adc_sample_valid ? (lvl.adc_mute ? 16'h0000 : adc_sample_in) : adc_q;
    dacv_d = dac_sample_valid;
    dac_d = dac_sample_valid ? (lvl.dac_mute ? 16'h0000 : dac_sample_in) : dac_q;
  end

  always_ff @(posedge sys_clk) begin
    if (rst || por) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      adc_q <= 16'h0000;
      dac_q <= 16'h0000;
      adcv_q <= 1'b0;
      dacv_q <= 1'b0;
      rs_q <= 18'h00000;
      rr_q <= 1'b0;
      dg_q <= 9'h000;
      ag_q <= 9'h000;
      dn_q <= 1'b0;
      dv_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      adc_q <= adc_d;
      dac_q <= dac_d;
      adcv_q <= adcv_d;
      dacv_q <= dacv_d;
      rs_q <= rs_w;
      rr_q <= rr_w;
      dg_q <= dg_w;
      ag_q <= ag_w;
      dn_q <= dn_w;
      dv_q <= dv_w;
    end
  end

  assign rdata = rdata_q;
  assign rvalid = rvalid_q;
  assign rate_reg_out = rate_q;
  assign rate_sevenths = rs_q;
  assign rate_reserved = rr_q;
  assign dac_force_mid = level_q[rate_level_pkg::DAC_MUTE_POS];
  assign dac_gain_tenths = dg_q;
  assign dac_gain_neg = dn_q;
  assign dac_gain_valid = dv_q;
  assign adc_input_select = level_q[rate_level_pkg::ADC_SEL_POS];
  assign adc_gain_tenths = ag_q;
  assign adc_sample_out = adc_q;
  assign adc_sample_out_valid = adcv_q;
  assign dac_sample_out = dac_q;
  assign dac_sample_out_valid = dacv_q;

  // checks
  AST_POR_RATE: assert property (@(posedge sys_clk) por |=> rate_q == 16'h3e80)
    else $error("rate not defaulted");
  AST_POR_LEVEL: assert property (@(posedge sys_clk) por |=> level_q == 16'h8080)
    else $error("level not defaulted");
  AST_RST_KEEP: assert property (@(posedge sys_clk) (rst && !por && !req.wr) |=> $stable(rate_q))
    else $error("reset changed rate");
  AST_DSP_LOW_HOLD: assert property (@(posedge sys_clk) disable iff (por)
      (dsp_mode && req.wr && rate_hit && req.lo_en && !req.hi_en) |=> $stable(rate_q))
    else $error("low byte took effect early");
  AST_DSP_HI_COMMIT: assert property (@(posedge sys_clk) disable iff (por)
      (dsp_mode && req.wr && rate_hit && req.hi_en && !req.lo_en) |=> rate_q[7:0] == $past(hold_q))
    else $error("hold not committed");
  AST_DSP_READ: assert property (@(posedge sys_clk) disable iff (rst || por)
      (dsp_mode && req.rd && rate_hit) |=> rdata[7:0] == $past(hold_q))
    else $error("low read not holding");
  AST_DIRECT_WR: assert property (@(posedge sys_clk) disable iff (por)
      (!dsp_mode && req.wr && rate_hit) |=> rate_q == $past(req.wdata))
    else $error("direct write lost");
  AST_ADC_MUTE: assert property (@(posedge sys_clk) disable iff (rst || por)
      (adc_sample_valid && lvl.adc_mute) |=> adc_sample_out == 16'h0000)
    else $error("adc not muted");
  AST_DAC_MUTE: assert property (@(posedge sys_clk) disable iff (rst || por)
      (dac_sample_valid && lvl.dac_mute) |=> dac_sample_out == 16'h0000)
    else $error("dac not muted");
  AST_RATE_DEFAULT: assert property (@(posedge sys_clk) disable iff (rst || por)
      (rate_q == 16'h3e80) |=> rate_sevenths == 18'h1b580)
    else $error("default rate wrong");
  AST_ATTEN_GATE: assert property (@(posedge sys_clk) disable iff (rst || por)
      codec_partner_select |=> !dac_gain_valid)
    else $error("attenuation valid off-chip");
  COV_DSP_SPLIT: cover property (@(posedge sys_clk)
      dsp_mode && req.wr && rate_hit && req.lo_en && !req.hi_en ##[1:4] req.wr && rate_hit && req.hi_en);
  COV_DIRECT: cover property (@(posedge sys_clk) !dsp_mode && req.wr && rate_hit);
  COV_UNMUTE: cover property (@(posedge sys_clk) req.wr && level_hit && req.hi_en && !req.wdata[15]);
  COV_RSVD_CODE: cover property (@(posedge sys_clk) rate_q[15:14] == 2'b11);
  COV_CAL_QUIET: cover property (@(posedge sys_clk) adc_calibrate && !req.wr);

  // rate follows the granularity code one flop behind the register
  AST_GRAN_1HZ: assert property (@(posedge sys_clk) disable iff (rst || por)
      (rate_q[15:14] == 2'b00) |=> rate_sevenths == 18'($past(rate_q[13:0])) * 18'h00007 && !rate_reserved)
    else $error("1 Hz step rate wrong");
  AST_GRAN_8_7HZ: assert property (@(posedge sys_clk) disable iff (rst || por)
      (rate_q[15:14] == 2'b01) |=> rate_sevenths == 18'($past(rate_q[13:0])) * 18'h00008 && !rate_reserved)
    else $error("8/7 Hz step rate wrong");
  AST_GRAN_10_7HZ: assert property (@(posedge sys_clk) disable iff (rst || por)
      (rate_q[15:14] == 2'b10) |=> rate_sevenths == 18'($past(rate_q[13:0])) * 18'h0000a && !rate_reserved)
    else $error("10/7 Hz step rate wrong");
  AST_GRAN_RSVD: assert property (@(posedge sys_clk) disable iff (rst || por)
      (rate_q[15:14] == 2'b11) |=> rate_reserved && rate_sevenths == 18'h00000)
    else $error("reserved code not flagged");

  // gain figures, recomputed from the step sizes
  AST_DAC_ATTEN: assert property (@(posedge sys_clk) disable iff (rst || por)
      1'b1 |=> (dac_gain_neg == ($past(lvl.dac_atten) > 5'h08))
      && ((dac_gain_neg ? -int'(dac_gain_tenths) : int'(dac_gain_tenths))
      == int'(rate_level_pkg::DAC_TOP_GAIN_TENTHS)
      - int'(rate_level_pkg::ATTEN_STEP_TENTHS) * int'($past(lvl.dac_atten))))
    else $error("dac attenuation step wrong");
  AST_ADC_GAIN: assert property (@(posedge sys_clk) disable iff (rst || por)
      1'b1 |=> adc_gain_tenths == 9'($past(lvl.adc_gain)) * 9'h00f + ($past(lvl.adc_boost) ? 9'h0c8 : 9'h000))
    else $error("adc gain sum wrong");
  AST_ATTEN_ON: assert property (@(posedge sys_clk) disable iff (rst || por)
      !codec_partner_select |=> dac_gain_valid)
    else $error("attenuation not valid on-chip");

  // unmuted samples pass one cycle late
  AST_ADC_PASS: assert property (@(posedge sys_clk) disable iff (rst || por)
      (adc_sample_valid && !lvl.adc_mute) |=> adc_sample_out == $past(adc_sample_in) && adc_sample_out_valid)
    else $error("adc sample not passed");
  AST_DAC_PASS: assert property (@(posedge sys_clk) disable iff (rst || por)
      (dac_sample_valid && !lvl.dac_mute) |=> dac_sample_out == $past(dac_sample_in) && dac_sample_out_valid)
    else $error("dac sample not passed");

  // read answers
  AST_READ_VALID: assert property (@(posedge sys_clk) disable iff (rst || por)
      req.rd |=> rvalid)
    else $error("read not answered");
  AST_READ_IDLE: assert property (@(posedge sys_clk) disable iff (rst || por)
      !req.rd |=> !rvalid)
    else $error("answer without read");
  AST_READ_HI: assert property (@(posedge sys_clk) disable iff (rst || por)
      (req.rd && rate_hit) |=> rdata[15:8] == $past(rate_q[15:8]))
    else $error("rate high byte read wrong");
  AST_PLAIN_READ: assert property (@(posedge sys_clk) disable iff (rst || por)
      (!dsp_mode && req.rd && rate_hit) |=> rdata == $past(rate_q))
    else $error("plain rate read wrong");
  AST_LEVEL_READ: assert property (@(posedge sys_clk) disable iff (rst || por)
      (req.rd && level_hit) |=> rdata == $past(level_q))
    else $error("level read wrong");

  // register writes and what leaves them alone
  AST_DSP_BOTH: assert property (@(posedge sys_clk) disable iff (por)
      (dsp_mode && req.wr && rate_hit && req.hi_en && req.lo_en) |=> rate_q == $past(req.wdata))
    else $error("full dsp write lost");
  AST_HOLD_LOAD: assert property (@(posedge sys_clk) disable iff (por)
      (dsp_mode && req.wr && rate_hit && req.lo_en) |=> hold_q == $past(req.wdata[7:0]))
    else $error("hold not loaded");
  AST_RATE_KEEP: assert property (@(posedge sys_clk) disable iff (por)
      !(req.wr && rate_hit) |=> $stable(rate_q))
    else $error("rate changed unwritten");
  AST_LEVEL_KEEP: assert property (@(posedge sys_clk) disable iff (por)
      !(req.wr && level_hit) |=> $stable(level_q))
    else $error("level changed unwritten");
  AST_LEVEL_HI_WR: assert property (@(posedge sys_clk) disable iff (por)
      (req.wr && level_hit && req.hi_en) |=> level_q[15] == $past(req.wdata[15])
      && level_q[12:8] == $past(req.wdata[12:8]))
    else $error("level high byte lost");
  AST_LEVEL_LO_WR: assert property (@(posedge sys_clk) disable iff (por)
      (req.wr && level_hit && req.lo_en) |=> level_q[7] == $past(req.wdata[7])
      && level_q[5:0] == $past(req.wdata[5:0]))
    else $error("level low byte lost");
  AST_POR_HOLD: assert property (@(posedge sys_clk) por |=> hold_q == 8'h80)
    else $error("hold not defaulted");
  AST_POR_MUTE: assert property (@(posedge sys_clk) por |=> dac_force_mid && lvl.adc_mute)
    else $error("mutes not defaulted");
endmodule

// *** rate_level_pkg.sv ***
// Function
// - the rate register loads 0x3e80 and the level register 0x8080 only on power-up, other resets keep them.
// - in dsp mode a low-byte rate write goes to a holding register and the rate changes only on the high-byte write.
// - in dsp mode a low-byte read of the rate register returns the holding register.
// - the granularity code sets one rate step to 1 Hz, 8/7 Hz or 10/7 Hz, code 11 being reserved.
// - the 14-bit rate value times the step weight is one common rate for adc and dac.
// - after power-up both converters run at 16000 Hz.
// - dac mute set forces the dac output to midscale, clear enables it.
// - the dac attenuation field steps 1.5 dB per count from +12.0 dB down to -34.5 dB.
// - dac attenuation applies only when the codec partner select is 0.
// - adc mute set replaces adc samples with midscale zero, clear passes them.
// - total adc gain is the 20 dB boost plus the gain level of 0.0 to 22.5 dB.
package rate_level_pkg;
  localparam logic [6:0] RATE_REG_ADDR = 7'h40;
  localparam logic [6:0] LEVEL_REG_ADDR = 7'h46;
  localparam logic [15:0] RATE_RESET = 16'h3e80;
  localparam logic [15:0] LEVEL_RESET = 16'h8080;
  localparam int DAC_MUTE_POS = 15;
  localparam int DAC_ATTEN_LSB = 8;
  localparam int ADC_MUTE_POS = 7;
  localparam int ADC_SEL_POS = 5;
  localparam int ADC_BOOST_POS = 4;
  localparam int ADC_GAIN_LSB = 0;
  localparam logic [15:0] LEVEL_WMASK = 16'h9fbf;
  // step weights in units of 1/7 Hz
  localparam logic [3:0] STEP_G0_SEVENTHS = 4'h7;
  localparam logic [3:0] STEP_G1_SEVENTHS = 4'h8;
  localparam logic [3:0] STEP_G2_SEVENTHS = 4'ha;
  // gains in tenths of a dB
  localparam logic [8:0] DAC_TOP_GAIN_TENTHS = 9'h078;
  localparam logic [8:0] ATTEN_STEP_TENTHS = 9'h00f;
  localparam logic [8:0] ADC_BOOST_TENTHS = 9'h0c8;
  localparam logic [8:0] ADC_STEP_TENTHS = 9'h00f;

  typedef enum logic [1:0] {
    GRAN_1HZ = 2'b00,
    GRAN_8_7HZ = 2'b01,
    GRAN_10_7HZ = 2'b10,
    GRAN_RSVD = 2'b11
  } gran_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic hi_en;
    logic lo_en;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic dac_mute;
    logic [4:0] dac_atten;
    logic adc_mute;
    logic adc_sel;
    logic adc_boost;
    logic [3:0] adc_gain;
  } level_t;
endpackage

// *** rate_calc.sv ***
`timescale 1ns/1ns
module rate_calc (
  input wire logic [15:0] rate_reg,
  output logic [17:0] rate_sevenths,
  output logic rate_reserved
);
  logic [3:0] step;
  // weight per count picked from granularity code
  always_comb begin
    rate_reserved = 1'b0;
    case (rate_level_pkg::gran_t'(rate_reg[15:14]))
      rate_level_pkg::GRAN_1HZ: step = rate_level_pkg::STEP_G0_SEVENTHS;
      rate_level_pkg::GRAN_8_7HZ: step = rate_level_pkg::STEP_G1_SEVENTHS;
      rate_level_pkg::GRAN_10_7HZ: step = rate_level_pkg::STEP_G2_SEVENTHS;
      default: begin
        step = 4'h0; // reserved code yields no rate
        rate_reserved = 1'b1;
      end
    endcase
    // widen before the product: a self-sized 14-bit product wraps above 16383
    rate_sevenths = 18'(rate_reg[13:0]) * 18'(step);
  end
endmodule

// *** level_calc.sv ***
`timescale 1ns/1ns
module level_calc (
  input wire rate_level_pkg::level_t lvl,
  input wire logic codec_partner_select,
  output logic [8:0] dac_gain_tenths,
  output logic dac_gain_neg,
  output logic dac_gain_valid,
  output logic [8:0] adc_gain_tenths
);
  logic [8:0] att;
  // dac: +12.0 dB minus 1.5 dB per count, signed magnitude
  always_comb begin
    att = 9'(lvl.dac_atten * rate_level_pkg::ATTEN_STEP_TENTHS);
    dac_gain_neg = att > rate_level_pkg::DAC_TOP_GAIN_TENTHS;
    dac_gain_tenths = dac_gain_neg ? 9'(att - rate_level_pkg::DAC_TOP_GAIN_TENTHS)
                                   : 9'(rate_level_pkg::DAC_TOP_GAIN_TENTHS - att);
    dac_gain_valid = !codec_partner_select;
    adc_gain_tenths = 9'(lvl.adc_gain * rate_level_pkg::ADC_STEP_TENTHS)
                      + (lvl.adc_boost ? rate_level_pkg::ADC_BOOST_TENTHS : 9'h000);
  end
endmodule

// *** host_model.sv ***
`timescale 1ns/1ns
module host_model (
  input wire logic sys_clk,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  output rate_level_pkg::reg_req_t req
);
  // idle request at time zero
  initial req = '0;
  // one-cycle write; callers never write during calibration, and t_plain also writes the reserved rate code 11
  task automatic wr(input logic [6:0] a, input logic [1:0] en, input logic [15:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, a, en[1], en[0], d};
    @(posedge sys_clk);
    req <= '{1'b0, 1'b0, ~a, 1'b0, 1'b0, ~d}; // released lines show the inverse, not stale data
  endtask
  // one-cycle read, answer waited for under a bound
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    int i;
    @(posedge sys_clk);
    req <= '{1'b0, 1'b1, a, 1'b0, 1'b0, 16'h0000};
    @(posedge sys_clk);
    req <= '{1'b0, 1'b0, ~a, 1'b0, 1'b0, 16'hffff};
    for (i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      if (rvalid === 1'b1) break;
    end
    d = rdata;
  endtask
endmodule

// *** tb_sample_rate_level_control.sv ***
`timescale 1ns/1ns
module tb_sample_rate_level_control;
  localparam logic [6:0] RA = rate_level_pkg::RATE_REG_ADDR;
  localparam logic [6:0] LA = rate_level_pkg::LEVEL_REG_ADDR;
  logic sys_clk = 1'b0, rst = 1'b1, por = 1'b1, dsp_mode = 1'b0, cps = 1'b0, av = 1'b0, dv = 1'b0;
  logic cal = 1'b0;
  logic [15:0] ain = 16'h0000, din = 16'h0000, rd_v, rdata, rate_reg_out, aout, dout;
  logic rvalid, rate_reserved, dac_force_mid, dgn, dgv, ais, aov, dov;
  logic [17:0] rate_sevenths;
  logic [8:0] dgt, agt;
  rate_level_pkg::reg_req_t req;
  int n_errors = 0, check_count = 0;
  // free-running 125 MHz clock
  always #4 sys_clk = ~sys_clk;
  sample_rate_level_control sample_rate_level_control_inst (.sys_clk(sys_clk), .rst(rst), .por(por),
    .dsp_mode(dsp_mode), .codec_partner_select(cps), .adc_calibrate(cal), .req(req), .rdata(rdata),
    .rvalid(rvalid), .rate_reg_out(rate_reg_out), .rate_sevenths(rate_sevenths), .rate_reserved(rate_reserved),
    .dac_force_mid(dac_force_mid), .dac_gain_tenths(dgt), .dac_gain_neg(dgn), .dac_gain_valid(dgv),
    .adc_input_select(ais), .adc_gain_tenths(agt), .adc_sample_in(ain), .adc_sample_valid(av),
    .adc_sample_out(aout), .adc_sample_out_valid(aov), .dac_sample_in(din), .dac_sample_valid(dv),
    .dac_sample_out(dout), .dac_sample_out_valid(dov));
  host_model host_model_inst (.sys_clk(sys_clk), .rdata(rdata), .rvalid(rvalid), .req(req));
  // compare and count
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // let the write land and the derived outputs follow
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // push one sample each way and compare the registered outputs
  task automatic samp(input logic [15:0] a, input logic [15:0] d, input logic [15:0] ea, input logic [15:0] ed);
    @(posedge sys_clk);
    {av, dv, ain, din} <= {2'b11, a, d};
    @(posedge sys_clk);
    {av, dv} <= 2'b00;
    @(negedge sys_clk);
    chk(aout, ea);
    chk(dout, ed);
    chk(aov, 1'b1);
    chk(dov, 1'b1);
  endtask
  task automatic t_power();
    host_model_inst.rd(RA, rd_v);
    chk(rd_v, 16'h3e80);
    host_model_inst.rd(LA, rd_v);
    chk(rd_v, 16'h8080);
    chk(rate_sevenths, 18'h1b580);
    chk(dac_force_mid, 1'b1);
    samp(16'h1234, 16'h5678, 16'h0000, 16'h0000);
    $display("power-up test done");
  endtask
  // plain reset must not touch the registers
  task automatic t_reset_keep();
    host_model_inst.wr(LA, 2'b11, 16'h1f3f);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    host_model_inst.rd(LA, rd_v);
    chk(rd_v, 16'h1f3f);
    host_model_inst.rd(RA, rd_v);
    chk(rd_v, 16'h3e80);
    $display("reset keep test done");
  endtask
  task automatic t_level();
    chk(dgt, 9'h159);
    chk(dgn, 1'b1);
    chk(dgv, 1'b1);
    chk(agt, 9'h1a9);
    chk(ais, 1'b1);
    samp(16'h1234, 16'h5678, 16'h1234, 16'h5678);
    // calibration window with no register writes
    @(posedge sys_clk);
    cps <= 1'b1;
    cal <= 1'b1;
    settle();
    chk(dgv, 1'b0);
    @(posedge sys_clk);
    cps <= 1'b0;
    cal <= 1'b0;
    host_model_inst.wr(LA, 2'b11, 16'h0000);
    settle();
    chk(dgt, 9'h078);
    chk(dgn, 1'b0);
    chk(agt, 9'h000);
    host_model_inst.wr(LA, 2'b11, 16'hffff);
    host_model_inst.wr(LA, 2'b01, 16'h0000);
    host_model_inst.rd(LA, rd_v);
    chk(rd_v, 16'h9f00);
    chk(dac_force_mid, 1'b1);
    $display("level test done");
  endtask
  // low byte parks in the holding register until the high byte arrives
  task automatic t_dsp();
    @(posedge sys_clk);
    dsp_mode <= 1'b1;
    host_model_inst.wr(RA, 2'b01, 16'h00e0);
    settle();
    chk(rate_reg_out, 16'h3e80);
    host_model_inst.rd(RA, rd_v);
    chk(rd_v, 16'h3ee0);
    host_model_inst.wr(RA, 2'b10, 16'h5500);
    settle();
    chk(rate_reg_out, 16'h55e0);
    chk(rate_sevenths, 18'h0af00);
    @(posedge sys_clk);
    dsp_mode <= 1'b0;
    $display("dsp hold test done");
  endtask
  task automatic t_plain();
    host_model_inst.wr(RA, 2'b01, 16'habc0);
    settle();
    chk(rate_reg_out, 16'habc0);
    chk(rate_sevenths, 18'h1b580);
    chk(rate_reserved, 1'b0);
    host_model_inst.wr(RA, 2'b11, 16'hc000);
    settle();
    chk(rate_reserved, 1'b1);
    host_model_inst.rd(7'h41, rd_v);
    chk(rd_v, 16'h0000);
    $display("plain mode test done");
  endtask
  // verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    por <= 1'b0;
    t_power();
    t_reset_keep();
    t_level();
    t_dsp();
    t_plain();
    results();
  end
  // watchdog, far beyond the roughly 70 cycles the tests need
  initial begin
    #100000;
    n_errors++;
    results();
  end
endmodule
